/* File: hw/asm_host.sv */
`timescale 1ns/1ps
`include "asm_map.svh"
module asm_host import asm_pkg::*; #(
  parameter int unsigned ADDR_W = `ASM_ADDR_W,
  parameter int unsigned DATA_W = `ASM_DATA_W,
  parameter int unsigned BUS_CYC = `ASM_BUS_CYC,
  parameter int unsigned LAT_CYC = `ASM_LAT_CYC,
  parameter int unsigned PC_CYC = `ASM_PC_CYC,
  parameter bit BYTE_MODE = 1'b0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // power state: low while supply ramps
  input wire logic i_power_good,
  // user request
  input wire logic i_req_valid,
  input wire asm_req_s i_req,
  output logic o_req_ready,
  output logic o_rdata_valid,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_row_open,
  // memory pins
  output asm_ctl_s o_mem_ctl,
  output logic [ADDR_W-1:0] o_mem_addr,
  output logic [DATA_W-1:0] o_mem_dq_out,
  output logic o_mem_dq_oe,
  input wire logic [DATA_W-1:0] i_mem_dq_in
);
  localparam int unsigned TW = 8;
  localparam logic [TW-1:0] ACC_LD = TW'(BUS_CYC - 1);
  localparam logic [TW-1:0] FIRST_LD = TW'(BUS_CYC + LAT_CYC - 1);
  localparam logic [TW-1:0] PC_LD = TW'(PC_CYC - 1);
  localparam asm_ctl_s CTL_IDLE = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};

  asm_state_e state_ff, nxt_state;
  asm_ctl_s ctl_ff, nxt_ctl;
  asm_req_s cur_ff, nxt_cur;
  logic [ADDR_W-1:0] addr_ff, nxt_addr;
  logic [DATA_W-1:0] dq_ff, nxt_dq, rdata_ff, nxt_rdata;
  logic oe_ff, nxt_oe, rvalid_ff, nxt_rvalid, ready_ff, nxt_ready;
  logic open_ff, nxt_open;
  logic tmr_load, tmr_done;
  logic [TW-1:0] tmr_value;
  logic same_row;
  logic [1:0] sel_n;

  asm_cycle_timer #(.WIDTH(TW)) u_timer (
    .i_clock(i_clock),
    .i_rst_n(i_rst_n),
    .i_load(tmr_load),
    .i_value(tmr_value),
    .o_done(tmr_done)
  );

  // pages only stay open while the row bits match
  assign same_row = (i_req.addr[ADDR_W-1:`ASM_ROW_LSB] ==
                     addr_ff[ADDR_W-1:`ASM_ROW_LSB]);

  // in byte mode the lane bit picks one select, lanes are tied outside
  always_comb begin
    if (BYTE_MODE) begin
      sel_n = i_req.byte_en[0] ? 2'h2 : 2'h1;
    end else begin
      sel_n = ~i_req.byte_en;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_ctl = ctl_ff;
    nxt_cur = cur_ff;
    nxt_addr = addr_ff;
    nxt_dq = dq_ff;
    nxt_rdata = rdata_ff;
    nxt_oe = oe_ff;
    nxt_rvalid = 1'b0;
    nxt_ready = 1'b0;
    tmr_load = 1'b0;
    tmr_value = ACC_LD;
    if (!i_power_good) begin
      // strobes parked high and bus released while supply moves
      nxt_state = ST_OFF;
      nxt_ctl = CTL_IDLE;
      nxt_oe = 1'b0;
    end else begin
      case (state_ff)
        ST_OFF: begin
          nxt_state = ST_OPEN;
          nxt_ready = 1'b1;
        end
        ST_OPEN: begin
          nxt_ready = 1'b1;
          if (i_req_valid && ready_ff) begin
            nxt_ready = 1'b0;
            if (!ctl_ff.chip_en_n && !same_row) begin
              // close the row ourselves so each row opens once
              nxt_state = ST_PRE;
              nxt_ctl = CTL_IDLE;
              nxt_oe = 1'b0;
              tmr_load = 1'b1;
              tmr_value = PC_LD;
            end else begin
              nxt_state = ST_ACC;
              nxt_cur = i_req;
              nxt_addr = i_req.addr;
              nxt_ctl.chip_en_n = 1'b0;
              nxt_ctl.write_n = ~i_req.write;
              nxt_ctl.output_en_n = i_req.write;
              nxt_ctl.upper_byte_select_n = sel_n[1];
              nxt_ctl.lower_byte_select_n = sel_n[0];
              nxt_dq = i_req.wdata;
              nxt_oe = i_req.write;
              tmr_load = 1'b1;
              // opening a row costs an extra latency slot
              tmr_value = ctl_ff.chip_en_n ? FIRST_LD : ACC_LD;
            end
          end
        end
        ST_ACC: begin
          if (tmr_done) begin
            nxt_state = ST_HOLD;
            nxt_ctl.write_n = 1'b1;
            if (!cur_ff.write) begin
              nxt_rdata = i_mem_dq_in;
              nxt_rvalid = 1'b1;
            end
          end
        end
        ST_HOLD: begin
          // write data held one cycle past the strobe rise
          nxt_state = ST_OPEN;
          nxt_oe = 1'b0;
          nxt_ctl.output_en_n = 1'b1;
          nxt_ready = 1'b1;
        end
        ST_PRE: begin
          if (tmr_done) begin
            nxt_state = ST_OPEN;
            nxt_ready = 1'b1;
          end
        end
        default: begin
          nxt_state = ST_OFF;
          nxt_ctl = CTL_IDLE;
          nxt_oe = 1'b0;
        end
      endcase
    end
    // registered copy so the row flag comes straight from a flop
    nxt_open = ~nxt_ctl.chip_en_n;
  end

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_ff <= ST_OFF;
      ctl_ff <= CTL_IDLE;
      cur_ff <= '0;
      addr_ff <= '0;
      dq_ff <= '0;
      rdata_ff <= '0;
      oe_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      ready_ff <= 1'b0;
      open_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ctl_ff <= nxt_ctl;
      cur_ff <= nxt_cur;
      addr_ff <= nxt_addr;
      dq_ff <= nxt_dq;
      rdata_ff <= nxt_rdata;
      oe_ff <= nxt_oe;
      rvalid_ff <= nxt_rvalid;
      ready_ff <= nxt_ready;
      open_ff <= nxt_open;
    end
  end

  assign o_mem_ctl = ctl_ff;
  assign o_mem_addr = addr_ff;
  assign o_mem_dq_out = dq_ff;
  assign o_mem_dq_oe = oe_ff;
  assign o_req_ready = ready_ff;
  assign o_rdata_valid = rvalid_ff;
  assign o_rdata = rdata_ff;
  assign o_row_open = open_ff;

  // helper: cycles the write strobe has been low
  logic [TW-1:0] wlow_ff, nxt_wlow;
  always_comb begin
    nxt_wlow = ctl_ff.write_n ? '0 : wlow_ff + TW'(1);
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wlow_ff <= '0;
    end else begin
      wlow_ff <= nxt_wlow;
    end
  end

  power_we_high_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !i_power_good |=> ctl_ff.write_n && ctl_ff.chip_en_n)
    else $error("write strobe low during power change");
  row_change_pre_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_ff == ST_OPEN) && i_req_valid && ready_ff && i_power_good && !same_row
      && !ctl_ff.chip_en_n |=> (state_ff == ST_PRE) && ctl_ff.chip_en_n)
    else $error("row change without precharge");
  precharge_len_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    $rose(ctl_ff.chip_en_n) && i_power_good |-> ctl_ff.chip_en_n [*2])
    else $error("precharge too short");
  row_stable_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    !ctl_ff.chip_en_n && !$past(ctl_ff.chip_en_n) |->
      o_mem_addr[ADDR_W-1:2] == $past(o_mem_addr[ADDR_W-1:2]))
    else $error("row changed while open");
  oe_not_read_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    o_mem_dq_oe |-> ctl_ff.output_en_n)
    else $error("bus fight on data lanes");
  strobe_bounded_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    wlow_ff <= TW'(BUS_CYC + LAT_CYC))
    else $error("write strobe held too long");
  byte_sel_one_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    BYTE_MODE && !ctl_ff.chip_en_n |->
      ctl_ff.upper_byte_select_n != ctl_ff.lower_byte_select_n)
    else $error("byte mode selects both lanes");
  read_answer_a: assert property (@(posedge i_clock) disable iff (!i_rst_n)
    (state_ff == ST_ACC) && !cur_ff.write && tmr_done && i_power_good |=> o_rdata_valid)
    else $error("read data not returned");
endmodule

/* File: common/asm_map.svh */
`ifndef ASM_MAP_SVH
`define ASM_MAP_SVH
// bus-side geometry of the memory
`define ASM_ADDR_W 17
`define ASM_DATA_W 16
`define ASM_COL_W 2
`define ASM_ROW_LSB 2
// 33 MHz page rate: one bus clock is about 30 ns
`define ASM_BUS_CLK_NS 30
`define ASM_CLK_NS 5
// least cycles per bus clock, rounded up
`define ASM_BUS_CYC ((`ASM_BUS_CLK_NS + `ASM_CLK_NS - 1) / `ASM_CLK_NS)
// extra bus clocks: first-word latency and precharge at 33 MHz
`define ASM_LAT_CLKS 1
`define ASM_PC_CLKS 2
`define ASM_PC_CYC (`ASM_PC_CLKS * `ASM_BUS_CYC)
`define ASM_LAT_CYC (`ASM_LAT_CLKS * `ASM_BUS_CYC)
`endif

/* File: common/asm_pkg.sv */
package asm_pkg;
  typedef struct packed {
    logic write;
    logic [1:0] byte_en;
    logic [16:0] addr;
    logic [15:0] wdata;
  } asm_req_s;
  typedef struct packed {
    logic chip_en_n;
    logic write_n;
    logic output_en_n;
    logic upper_byte_select_n;
    logic lower_byte_select_n;
  } asm_ctl_s;
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_OPEN = 5'h02,
    ST_ACC = 5'h04,
    ST_HOLD = 5'h08,
    ST_PRE = 5'h10
  } asm_state_e;
endpackage

/* File: hw/asm_cycle_timer.sv */
`timescale 1ns/1ps
// loadable down-counter; o_done high while the count is zero
module asm_cycle_timer #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // control
  input wire logic i_load,
  input wire logic [WIDTH-1:0] i_value,
  // status
  output logic o_done
);
  logic [WIDTH-1:0] count_ff;
  logic [WIDTH-1:0] nxt_count;
  always_comb begin
    nxt_count = count_ff;
    if (i_load) begin
      nxt_count = i_value;
    end else if (count_ff != '0) begin
      nxt_count = count_ff - WIDTH'(1);
    end
  end
  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end
  assign o_done = (count_ff == '0);
endmodule

/* File: testbench/asm_mem_model.sv */
`timescale 1ns/1ps
module asm_mem_model import asm_pkg::*; (
  // clock
  input wire logic i_clock,
  // memory pins
  input wire asm_ctl_s i_ctl,
  input wire logic [16:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_dq_oe,
  output logic [15:0] o_dq,
  // row openings, one endurance cycle each
  output int o_opens
);
  logic [15:0] mem [0:131071];
  logic [14:0] row_ff;
  logic open_ff;
  logic [15:0] last_ff;
  initial begin
    o_opens = 0;
    open_ff = 1'b0;
    row_ff = 15'h0;
    last_ff = 16'h0;
  end
  always @(posedge i_clock) begin
    last_ff <= o_dq;
    if (i_ctl.chip_en_n) begin
      open_ff <= 1'b0;
    end else if (!open_ff || row_ff != i_addr[16:2]) begin
      open_ff <= 1'b1;
      row_ff <= i_addr[16:2];
      o_opens <= o_opens + 1;
    end
    if (!i_ctl.chip_en_n && !i_ctl.write_n && i_dq_oe) begin
      if (!i_ctl.upper_byte_select_n) mem[i_addr][15:8] <= i_dq[15:8];
      if (!i_ctl.lower_byte_select_n) mem[i_addr][7:0] <= i_dq[7:0];
    end
  end
  // released lanes show changing junk so a stale value cannot pass
  always @* begin
    o_dq = ~last_ff;
    if (!i_ctl.chip_en_n && !i_ctl.output_en_n) begin
      if (!i_ctl.upper_byte_select_n) o_dq[15:8] = mem[i_addr][15:8];
      if (!i_ctl.lower_byte_select_n) o_dq[7:0] = mem[i_addr][7:0];
    end
  end
endmodule

/* File: testbench/asm_host_test.sv */
`timescale 1ns/1ps
module asm_host_test;
  import asm_pkg::*;
  logic i_clock, i_rst_n, i_power_good, i_req_valid, o_req_ready, o_rdata_valid, o_row_open;
  asm_req_s i_req;
  asm_ctl_s o_mem_ctl;
  logic [15:0] o_rdata, o_mem_dq_out, i_mem_dq_in, d;
  logic [16:0] o_mem_addr;
  logic o_mem_dq_oe;
  int opens, fails, checked, l, o;
  localparam int unsigned BC = 2, LC = 2, PC = 2;
  asm_ctl_s b_ctl;
  logic [16:0] b_addr;
  logic [15:0] b_dq, b_dq_in;
  logic b_oe;
  asm_host #(.BUS_CYC(BC), .LAT_CYC(LC), .PC_CYC(PC)) asm_host_i (.i_clock(i_clock),
    .i_rst_n(i_rst_n), .i_power_good(i_power_good), .i_req_valid(i_req_valid),
    .i_req(i_req), .o_req_ready(o_req_ready), .o_rdata_valid(o_rdata_valid),
    .o_rdata(o_rdata), .o_row_open(o_row_open), .o_mem_ctl(o_mem_ctl),
    .o_mem_addr(o_mem_addr), .o_mem_dq_out(o_mem_dq_out), .o_mem_dq_oe(o_mem_dq_oe),
    .i_mem_dq_in(i_mem_dq_in));
  asm_mem_model asm_mem_model_i (.i_clock(i_clock), .i_ctl(o_mem_ctl), .i_addr(o_mem_addr),
    .i_dq(o_mem_dq_out), .i_dq_oe(o_mem_dq_oe), .o_dq(i_mem_dq_in), .o_opens(opens));
  // byte-lane twin: same requests, same timing, only the selects differ
  asm_host #(.BUS_CYC(BC), .LAT_CYC(LC), .PC_CYC(PC), .BYTE_MODE(1'b1)) asm_host_byte_i (
    .i_clock(i_clock), .i_rst_n(i_rst_n), .i_power_good(i_power_good),
    .i_req_valid(i_req_valid), .i_req(i_req), .o_req_ready(), .o_rdata_valid(),
    .o_rdata(), .o_row_open(), .o_mem_ctl(b_ctl), .o_mem_addr(b_addr),
    .o_mem_dq_out(b_dq), .o_mem_dq_oe(b_oe), .i_mem_dq_in(b_dq_in));
  asm_mem_model asm_mem_model_byte_i (.i_clock(i_clock), .i_ctl(b_ctl), .i_addr(b_addr),
    .i_dq(b_dq), .i_dq_oe(b_oe), .o_dq(b_dq_in), .o_opens());
  initial begin
    i_clock = 1'b0;
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic give_verdict;
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // rf: first take on a new row is only a precharge and must be offered again
  task automatic acc(input logic wr, input logic [1:0] be, input logic [16:0] a,
      input logic [15:0] wd, input bit rf, output logic [15:0] rd, output int lat);
    logic r;
    int n;
    i_req = '{write: wr, byte_en: be, addr: a, wdata: wd};
    i_req_valid = 1'b1;
    for (n = 0; n < 60; n++) begin
      @(negedge i_clock);
      r = o_req_ready;
      @(posedge i_clock);
      #1;
      if (r === 1'b1 && !rf) break;
      if (r === 1'b1) rf = 1'b0;
    end
    i_req_valid = 1'b0;
    // a write returns one edge late so the next take never shares this time step
    if (wr) begin
      @(posedge i_clock);
      #1;
    end
    cmp(n < 60, 1);
    rd = 16'h0;
    for (lat = 0; !wr && lat < 40 && o_rdata_valid !== 1'b1; lat++) begin
      @(posedge i_clock);
      #1;
    end
    if (!wr) cmp(o_rdata_valid, 1);
    if (!wr) rd = o_rdata;
  endtask
  task automatic t_page;
    o = opens;
    for (int k = 0; k < 4; k++) acc(1, 2'b11, 17'h00400 + 17'(k), 16'h1110 * 16'(k + 1), 0, d, l);
    for (int k = 3; k >= 0; k--) begin
      acc(0, 2'b11, 17'h00400 + 17'(k), 16'h0, 0, d, l);
      cmp(d, 16'h1110 * 16'(k + 1));
    end
    cmp(l, BC);
    cmp(opens - o, 1);
    cmp(o_row_open, 1);
  endtask
  task automatic t_bytes;
    acc(1, 2'b01, 17'h00401, 16'hffaa, 0, d, l);
    cmp({b_ctl.upper_byte_select_n, b_ctl.lower_byte_select_n}, 2'h2);
    acc(1, 2'b10, 17'h00402, 16'hbbff, 0, d, l);
    cmp({b_ctl.upper_byte_select_n, b_ctl.lower_byte_select_n}, 2'h1);
    acc(0, 2'b11, 17'h00401, 16'h0, 0, d, l);
    cmp(d, 16'h22aa);
    acc(0, 2'b11, 17'h00402, 16'h0, 0, d, l);
    cmp(d, 16'hbb30);
  endtask
  task automatic t_row;
    o = opens;
    acc(1, 2'b11, 17'h00404, 16'h5a5a, 1, d, l);
    cmp(o_mem_addr, 17'h00404);
    cmp(o_mem_dq_out, 16'h5a5a);
    cmp(opens - o, 1);
    acc(0, 2'b11, 17'h00401, 16'h0, 1, d, l);
    cmp(d, 16'h22aa);
    cmp(opens - o, 2);
  endtask
  // supply drop with the row open: strobes must park high
  task automatic t_power;
    i_power_good = 1'b0;
    repeat (2) @(posedge i_clock);
    #1;
    cmp(o_mem_ctl.write_n, 1);
    cmp(o_mem_dq_oe, 0);
    // chip enable is host-driven, never hard-wired, so protection stays usable
    cmp(o_mem_ctl.chip_en_n, 1);
    i_power_good = 1'b1;
    acc(0, 2'b11, 17'h00404, 16'h0, 0, d, l);
    cmp(d, 16'h5a5a);
    cmp(l, BC + LC);
  endtask
  initial begin
    #20000;
    fails++;
    give_verdict;
  end
  initial begin
    i_rst_n = 1'b0;
    i_power_good = 1'b0;
    i_req_valid = 1'b0;
    i_req = '0;
    repeat (10) @(posedge i_clock);
    #1;
    i_rst_n = 1'b1;
    repeat (3) @(posedge i_clock);
    #1;
    cmp(o_mem_ctl, 5'h1f);
    i_power_good = 1'b1;
    t_page;
    t_bytes;
    t_row;
    t_power;
    give_verdict;
  end
endmodule
